// ### common/cwl_pkg.sv
/*
 Package for the configuration register write lock: the bank bus carrier,
 key values, bank geometry and the lock state encoding.
 Assumes one clock, and a bank of word registers behind one shared bus.
 */
// Overview of operation
// - Power-on reset puts the bank into the locked state.
// - While locked, bank writes are dropped; reads still return stored data.
// - Unlock needs an exact-key write to each of the two key registers.
// - Unlocked: writable registers take writes, read-only registers never change.
// - Any other value written to a key register locks the bank again.
// - One key pair and one lock state serve every processor core.
package cwl_pkg;

   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BANK_WORDS = 16;
   localparam int unsigned IDX_W = 4;

   // Word indices of the two key registers, above the bank
   localparam logic [ADDR_W-1:0] UNLOCK_KEY_FIRST_IDX = 6'h20;
   localparam logic [ADDR_W-1:0] UNLOCK_KEY_SECOND_IDX = 6'h21;
   // Bank occupies word indices 0 to 15
   localparam logic [ADDR_W-1:0] BANK_LIMIT_IDX = 6'h10;

   // Key values, arbitrary
   localparam logic [DATA_W-1:0] KEY_FIRST_VAL = 32'h5a3c_96e1;
   localparam logic [DATA_W-1:0] KEY_SECOND_VAL = 32'h1e69_c3a5;

   // Bit per bank word: 1 = writable; upper four words are read-only
   localparam logic [BANK_WORDS-1:0] BANK_WRITABLE = 16'h0fff;
   localparam logic [DATA_W-1:0] BANK_RESET_VAL = 32'h0000_0000;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

   // Key sequence states
   typedef enum logic [1:0]
   {
      LK_LOCKED = 2'b00,
      LK_FIRST_OK = 2'b01,
      LK_OPEN = 2'b10
   } cwl_lock_t;

   // Register access request from any core
   typedef struct packed
   {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cwl_req_t;

   // Answer to the request, one cycle later
   typedef struct packed
   {
      logic valid;
      logic err;
      logic [DATA_W-1:0] rdata;
   } cwl_rsp_t;

endpackage

// ### src/cwl_bank_mem.sv
/*
 Storage for the protected configuration bank: one write port, one read port,
 read data from a register. Assumes the caller gates write enable.
 */
`timescale 1ns/1ps
`default_nettype none
module cwl_bank_mem
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [cwl_pkg::IDX_W-1:0] wr_idx,
   input wire logic [cwl_pkg::DATA_W-1:0] wr_data,
   input wire logic [cwl_pkg::IDX_W-1:0] rd_idx,
   output logic [cwl_pkg::DATA_W-1:0] rd_data
);
   import cwl_pkg::*;

   typedef struct packed
   {
      logic [BANK_WORDS-1:0][DATA_W-1:0] word;
      logic [DATA_W-1:0] rd;
   } cwl_mem_t;

   cwl_mem_t s_q;
   cwl_mem_t s_d;

   // Write gated by caller, registered read
   always_comb
   begin
      s_d = s_q;
      if (wr_en)
      begin
         s_d.word[wr_idx] = wr_data;
      end
      s_d.rd = s_q.word[rd_idx];
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '{word: {BANK_WORDS{BANK_RESET_VAL}}, rd: BANK_RESET_VAL};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd;

endmodule // cwl_bank_mem
`default_nettype wire

// ### src/cwl_write_lock.sv
/*
 Configuration bank with a two-key write lock, shared by all cores.
 Assumes requests come from logic on the same clock, one per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module cwl_write_lock
(
   input wire logic clock,
   input wire logic nrst,
   input wire cwl_pkg::cwl_req_t req,
   output cwl_pkg::cwl_rsp_t rsp,
   output logic unlocked
);
   import cwl_pkg::*;

   // Word index inside the protected bank
   function automatic logic in_bank(input logic [ADDR_W-1:0] a);
      in_bank = (a < BANK_LIMIT_IDX);
   endfunction

   // Word index of either key register
   function automatic logic is_key(input logic [ADDR_W-1:0] a);
      is_key = (a == UNLOCK_KEY_FIRST_IDX) || (a == UNLOCK_KEY_SECOND_IDX);
   endfunction

   typedef struct packed
   {
      cwl_lock_t lock;
      logic rsp_valid;
      logic rsp_err;
      logic rd_bank;
      logic [DATA_W-1:0] rd_other;
   } cwl_state_t;

   cwl_state_t s_q;
   cwl_state_t s_d;
   logic wr_bank;
   logic [IDX_W-1:0] idx;
   logic [DATA_W-1:0] mem_rd;
   logic key1_wr;
   logic key2_wr;

   assign idx = req.addr[IDX_W-1:0];
   assign key1_wr = req.valid && req.write && (req.addr == UNLOCK_KEY_FIRST_IDX);
   assign key2_wr = req.valid && req.write && (req.addr == UNLOCK_KEY_SECOND_IDX);

   // Bank write only when open and the word is writable
   assign wr_bank = req.valid && req.write && in_bank(req.addr)
                    && (s_q.lock == LK_OPEN)
                    && BANK_WRITABLE[idx];

   cwl_bank_mem u_mem
   (
      .clock(clock),
      .nrst(nrst),
      .wr_en(wr_bank),
      .wr_idx(idx),
      .wr_data(req.wdata),
      .rd_idx(idx),
      .rd_data(mem_rd)
   );

   // Key sequence and response
   always_comb
   begin
      s_d = s_q;
      s_d.rsp_valid = req.valid;
      s_d.rsp_err = 1'b0;
      s_d.rd_bank = 1'b0;
      s_d.rd_other = UNMAPPED_READ;
      // Key writes step or drop the lock
      if (key1_wr)
      begin
         if (req.wdata == KEY_FIRST_VAL)
         begin
            if (s_q.lock == LK_LOCKED)
            begin
               s_d.lock = LK_FIRST_OK;
            end
         end
         else
         begin
            s_d.lock = LK_LOCKED;
         end
      end
      else if (key2_wr)
      begin
         if (req.wdata != KEY_SECOND_VAL)
         begin
            s_d.lock = LK_LOCKED;
         end
         else if (s_q.lock == LK_FIRST_OK)
         begin
            s_d.lock = LK_OPEN;
         end
      end
      // Read path and error flag
      if (req.valid && !req.write)
      begin
         if (in_bank(req.addr))
         begin
            s_d.rd_bank = 1'b1;
         end
         else if (is_key(req.addr))
         begin
            s_d.rd_other = {{(DATA_W-2){1'b0}}, s_q.lock};
         end
         else
         begin
            s_d.rsp_err = 1'b1;
         end
      end
      else if (req.valid && !in_bank(req.addr) && !key1_wr && !key2_wr)
      begin
         s_d.rsp_err = 1'b1;
      end
   end

   // Register the state copy; power-on reset locks the bank
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '{lock: LK_LOCKED, rsp_valid: 1'b0, rsp_err: 1'b0, rd_bank: 1'b0, rd_other: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Response one cycle after request
   always_comb
   begin
      rsp.valid = s_q.rsp_valid;
      rsp.err = s_q.rsp_err;
      rsp.rdata = s_q.rd_bank ? mem_rd : s_q.rd_other;
   end

   // Open flag, shared by every core
   assign unlocked = (s_q.lock == LK_OPEN);

   // Checks, all on the one bus clock
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // Bank write gating
   a_locked_no_write: assert property (
      s_q.lock != LK_OPEN |-> !wr_bank)
      else $error("bank write while locked");

   a_ro_no_write: assert property (
      s_q.rd_bank && !BANK_WRITABLE[$past(idx)] |-> rsp.rdata == BANK_RESET_VAL)
      else $error("read-only word changed");

   a_open_write_lands: assert property (
      req.valid && req.write && in_bank(req.addr) && unlocked && BANK_WRITABLE[idx] |-> wr_bank)
      else $error("open writable write dropped");

   // Key sequence
   a_bad_key_locks: assert property (
      (key1_wr && req.wdata != KEY_FIRST_VAL) || (key2_wr && req.wdata != KEY_SECOND_VAL)
      |=> s_q.lock == LK_LOCKED)
      else $error("wrong key did not lock");

   a_first_key_step: assert property (
      key1_wr && req.wdata == KEY_FIRST_VAL && s_q.lock == LK_LOCKED |=> s_q.lock == LK_FIRST_OK)
      else $error("first key not taken");

   a_unlock_timing: assert property (
      key2_wr && req.wdata == KEY_SECOND_VAL && s_q.lock == LK_FIRST_OK |=> unlocked)
      else $error("unlock not one cycle after second key");

   a_unlock_cause: assert property (
      $rose(unlocked) |-> $past(key2_wr) && $past(req.wdata) == KEY_SECOND_VAL)
      else $error("unlock without second key");

   a_first_needed: assert property (
      s_q.lock == LK_LOCKED && !key1_wr |=> !unlocked)
      else $error("unlock skipped first key");

   a_open_holds: assert property (
      unlocked && !key1_wr && !key2_wr |=> unlocked)
      else $error("bank locked without key write");

   a_first_keeps_open: assert property (
      key1_wr && req.wdata == KEY_FIRST_VAL && unlocked |=> unlocked)
      else $error("first key closed the bank");

   // Responses
   a_read_answers: assert property (
      req.valid && !req.write |=> rsp.valid)
      else $error("read not answered");

   a_idle_no_rsp: assert property (
      !req.valid |=> !rsp.valid)
      else $error("answer without request");

   a_bank_no_err: assert property (
      req.valid && in_bank(req.addr) |=> !rsp.err)
      else $error("bank access flagged");

   a_key_write_quiet: assert property (
      key1_wr || key2_wr |=> !rsp.err)
      else $error("key write flagged");

   a_unmapped_err: assert property (
      req.valid && !in_bank(req.addr) && !is_key(req.addr) |=> rsp.valid && rsp.err)
      else $error("unmapped access not flagged");

   a_key_read_state: assert property (
      req.valid && !req.write && is_key(req.addr) |=> rsp.rdata == {{(DATA_W-2){1'b0}}, $past(s_q.lock)})
      else $error("key read not lock state");

   // Main scenarios
   c_unlock: cover property ($rose(unlocked));
   c_relock: cover property ($fell(unlocked));
   c_open_write: cover property (wr_bank);
   c_locked_write: cover property (req.valid && req.write && in_bank(req.addr) && !unlocked);
   c_key_read: cover property (req.valid && !req.write && is_key(req.addr));

endmodule // cwl_write_lock
`default_nettype wire

// ### bench/tb_cwl_write_lock.sv
/*
 Self-checking bench for the configuration write lock: reset lock, key order,
 relock on a wrong key, read-only words, unmapped access.
 Assumes the lock block and its package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_cwl_write_lock;
   import cwl_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   cwl_req_t req = '0;
   cwl_rsp_t rsp;
   logic unlocked;
   int mismatches = 0;
   int num_checks = 0;
   logic [31:0] rd;
   localparam logic [31:0] VA = 32'h1234_abcd;

   cwl_write_lock i_dut (.clock(clock), .nrst(nrst), .req(req), .rsp(rsp), .unlocked(unlocked));

   // Clock, 5 ns period
   always #2.5 clock = ~clock;

   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One request; answer sampled one cycle later, after valid is dropped
   task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d, input logic e);
      @(posedge clock);
      #1 req = '{1'b1, w, a, d};
      @(posedge clock);
      #1 req.valid = 1'b0;
      chk("rsp valid", 32'(rsp.valid), 32'h1);
      chk("rsp err", 32'(rsp.err), 32'(e));
      rd = rsp.rdata;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0, 1'b0);
      chk("read data", rd, exp);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic t_reset;
      repeat (4) @(posedge clock);
      #1 nrst = 1'b1;
      chk("unlocked", 32'(unlocked), 32'h0);
      rdc(6'h03, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_locked;
      acc(1'b1, 6'h03, VA, 1'b0);
      rdc(6'h03, 32'h0);
      acc(1'b1, UNLOCK_KEY_SECOND_IDX, KEY_SECOND_VAL, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h0);
      // Near-miss first key must not count
      acc(1'b1, UNLOCK_KEY_FIRST_IDX, KEY_FIRST_VAL ^ 32'h8000_0000, 1'b0);
      acc(1'b1, UNLOCK_KEY_SECOND_IDX, KEY_SECOND_VAL, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h0);
      $display("test locked done");
   endtask

   task automatic t_unlock;
      acc(1'b1, UNLOCK_KEY_FIRST_IDX, KEY_FIRST_VAL, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h0);
      rdc(UNLOCK_KEY_SECOND_IDX, 32'(LK_FIRST_OK));
      acc(1'b1, 6'h05, VA, 1'b0);
      acc(1'b1, UNLOCK_KEY_SECOND_IDX, KEY_SECOND_VAL, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h1);
      rdc(UNLOCK_KEY_FIRST_IDX, 32'(LK_OPEN));
      rdc(6'h05, 32'h0);
      acc(1'b1, 6'h03, VA, 1'b0);
      acc(1'b1, 6'h0b, ~VA, 1'b0);
      acc(1'b1, 6'h0c, VA, 1'b0);
      rdc(6'h03, VA);
      rdc(6'h0b, ~VA);
      rdc(6'h0c, 32'h0);
      chk("unlocked", 32'(unlocked), 32'h1);
      $display("test unlock done");
   endtask

   task automatic t_relock;
      acc(1'b1, UNLOCK_KEY_SECOND_IDX, KEY_SECOND_VAL ^ 32'h1, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h0);
      acc(1'b1, 6'h03, 32'h0, 1'b0);
      rdc(6'h03, VA);
      acc(1'b1, UNLOCK_KEY_FIRST_IDX, KEY_FIRST_VAL, 1'b0);
      acc(1'b1, UNLOCK_KEY_SECOND_IDX, KEY_SECOND_VAL, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h1);
      acc(1'b1, UNLOCK_KEY_FIRST_IDX, 32'h0, 1'b0);
      chk("unlocked", 32'(unlocked), 32'h0);
      $display("test relock done");
   endtask

   task automatic t_unmapped;
      acc(1'b1, 6'h30, VA, 1'b1);
      acc(1'b0, BANK_LIMIT_IDX, 32'h0, 1'b1);
      chk("unmapped data", rd, UNMAPPED_READ);
      $display("test unmapped done");
   endtask

   // Main sequence
   initial
   begin
      t_reset();
      t_locked();
      t_unlock();
      t_relock();
      t_unmapped();
      end_sim();
   end

   // Watchdog, well past the roughly 56 cycles the tests need
   initial
   begin
      #20000;
      mismatches++;
      end_sim();
   end
endmodule // tb_cwl_write_lock
`default_nettype wire
